/* File: rtl/rngmon_pkg.sv */
package rngmon_pkg;
  localparam logic [7:0] RNGMON_CTRL_OFS = 8'h80;
  localparam logic [7:0] RNGMON_CALC_OFS = 8'h84;
  localparam logic [7:0] RNGMON_DONE_OFS = 8'h88;
  localparam logic [7:0] RNGMON_CYC_OFS = 8'h8c;
  localparam logic [7:0] RNGMON_IRQ_STAT_OFS = 8'h90;
  localparam logic [7:0] RNGMON_IRQ_EN_OFS = 8'h94;
  localparam logic [7:0] RNGMON_IRQ_CLR_OFS = 8'h98;
  localparam int RNGMON_START_BIT = 0;
  localparam int RNGMON_EN_BIT = 1;
  localparam int RNGMON_SEL_LSB = 2;
  localparam int RNGMON_WE_LSB = 16;
  localparam logic [15:0] RNGMON_CTRL_RST = 16'h0000;
  localparam logic [15:0] RNGMON_CTRL_MASK = 16'h000f;
  localparam logic [31:0] RNGMON_CALC_RST = 32'h0000_0000;
  localparam logic [1:0] RNGMON_SEL_RESERVED = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rngmon_bus_s;

  typedef enum logic [1:0] {
    RNGMON_IDLE,
    RNGMON_COUNT,
    RNGMON_DONE
  } rngmon_state_e;
endpackage : rngmon_pkg

/* File: rtl/rngmon_top.sv */
// Notes on behaviour
// - A control write updates lower bit n only when the same write sets upper bit n+16.
// - The enable mapping reaches bit 31, which gates lower bit 15.
// - Control bits 3:2 select ring 0, 1 or 2; code 3 is reserved.
// - Control bit 1 enables the selected ring while high.
// - Control bit 0 starts a measurement and resets to zero.
// - A 32-bit writable calculation count sets the measurement window length.
// - Done status bit 0 marks a finished count; bits 31:1 read zero.
// - A 32-bit field reports rising ring clock edges counted in the window.
`timescale 1ns/1ps
module rngmon_top
  import rngmon_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_resetn,
  // Register port.
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Ring oscillators, sampled as synchronous levels.
  input wire logic [2:0] i_ring_clk,
  output logic [2:0] o_ring_en,
  // Interrupt.
  output logic o_irq
);

  // Address match, used by the write decode; the read multiplexer decodes the address in its own case.
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = a == ofs;
  endfunction : addr_is

  // The lower half follows the data only where the upper half enables it.
  function automatic logic [15:0] masked_write(input logic [15:0] old, input logic [31:0] wd);
    masked_write = (wd[15:0] & wd[RNGMON_WE_LSB+:16]) | (old & ~wd[RNGMON_WE_LSB+:16]);
  endfunction : masked_write

  // The reserved selector code drives no ring at all, so no stray oscillator runs.
  function automatic logic [2:0] ring_onehot(input logic [1:0] s, input logic on);
    ring_onehot = 3'h0;
    if (on && s != RNGMON_SEL_RESERVED) begin
      ring_onehot[s] = 1'b1;
    end
  endfunction : ring_onehot

  // Register port carrier.
  rngmon_bus_s bus;

  // Stored registers.
  logic [15:0] ctrl;
  logic [31:0] calc_cnt;
  logic [31:0] cyc_cnt;
  logic [31:0] edge_cnt;
  logic [31:0] win_cnt;
  logic done;
  logic irq_stat;
  logic irq_en;
  logic ring_prev;
  rngmon_state_e state;

  // Next values.
  logic [15:0] next_ctrl;
  logic [31:0] next_calc_cnt;
  logic [31:0] next_cyc_cnt;
  logic [31:0] next_edge_cnt;
  logic [31:0] next_win_cnt;
  logic next_done;
  logic next_irq_stat;
  logic next_irq_en;
  logic next_ring_prev;
  rngmon_state_e next_state;
  logic [31:0] next_rdata;

  // Decode wires.
  logic wr_ctrl;
  logic wr_calc;
  logic wr_en;
  logic wr_clr;
  logic [1:0] sel;
  logic ring_on;
  logic ring_lvl;
  logic ring_rise;
  logic start;
  logic counting;
  logic win_end;
  logic done_evt;
  logic clr_req;
  logic [31:0] edge_sum;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // Write decode.
  assign wr_ctrl = bus.wr && addr_is(bus.addr, RNGMON_CTRL_OFS);
  assign wr_calc = bus.wr && addr_is(bus.addr, RNGMON_CALC_OFS);
  assign wr_en = bus.wr && addr_is(bus.addr, RNGMON_IRQ_EN_OFS);
  assign wr_clr = bus.wr && addr_is(bus.addr, RNGMON_IRQ_CLR_OFS);

  // Control register.
  // Only the four implemented bits are stored; reserved bits 15:4 read zero.
  // Bit 31 therefore gates a bit that always stays zero, but the mapping is kept whole.
  assign next_ctrl = masked_write(ctrl, bus.wdata) & RNGMON_CTRL_MASK;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl <= RNGMON_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= next_ctrl;
    end
  end

  // Calculation count register.
  assign next_calc_cnt = wr_calc ? bus.wdata : calc_cnt;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      calc_cnt <= RNGMON_CALC_RST;
    end else begin
      calc_cnt <= next_calc_cnt;
    end
  end

  // Ring selection and enable.
  assign sel = ctrl[RNGMON_SEL_LSB+:2];
  assign ring_on = ctrl[RNGMON_EN_BIT] && sel != RNGMON_SEL_RESERVED;
  assign o_ring_en = ring_onehot(sel, ctrl[RNGMON_EN_BIT]);

  // Ring edge detection.
  // The previous level resets low, which matches a disabled ring, so no false edge follows.
  assign ring_lvl = ring_on ? i_ring_clk[sel] : 1'b0;
  assign ring_rise = ring_lvl && !ring_prev;
  assign next_ring_prev = ring_lvl;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ring_prev <= 1'b0;
    end else begin
      ring_prev <= next_ring_prev;
    end
  end

  // Measurement control.
  // A start is a 0-to-1 transition of the start bit, so holding it high runs one measurement.
  // Software must write the bit low again before the next start; this avoids restarts
  // from unrelated control writes that leave the start bit set.
  assign start = wr_ctrl && next_ctrl[RNGMON_START_BIT] && !ctrl[RNGMON_START_BIT];
  assign counting = state == RNGMON_COUNT;
  // A count of zero still gives a window of one cycle, so a measurement always ends.
  assign win_end = counting && win_cnt + 32'd1 >= calc_cnt;
  assign done_evt = win_end && !start;

  always_comb begin
    next_state = state;
    if (start) begin
      next_state = RNGMON_COUNT;
    end else begin
      case (state)
        RNGMON_COUNT: begin
          if (win_end) begin
            next_state = RNGMON_DONE;
          end
        end
        RNGMON_DONE: begin
          next_state = RNGMON_DONE;
        end
        RNGMON_IDLE: begin
          next_state = RNGMON_IDLE;
        end
        default: begin
          next_state = RNGMON_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= RNGMON_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Window counter.
  assign next_win_cnt = start ? 32'h0000_0000 : counting ? win_cnt + 32'd1 : win_cnt;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      win_cnt <= 32'h0000_0000;
    end else begin
      win_cnt <= next_win_cnt;
    end
  end

  // Edge counter.
  // The edge of the last window cycle is included through edge_sum.
  assign edge_sum = edge_cnt + {31'h0, ring_rise};
  assign next_edge_cnt = start ? 32'h0000_0000 : counting ? edge_sum : edge_cnt;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      edge_cnt <= 32'h0000_0000;
    end else begin
      edge_cnt <= next_edge_cnt;
    end
  end

  // Result and done flag.
  // A new start clears both, even when it falls in the last window cycle.
  assign next_cyc_cnt = start ? 32'h0000_0000 : done_evt ? edge_sum : cyc_cnt;
  assign next_done = start ? 1'b0 : done_evt ? 1'b1 : done;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      cyc_cnt <= 32'h0000_0000;
    end else begin
      cyc_cnt <= next_cyc_cnt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      done <= 1'b0;
    end else begin
      done <= next_done;
    end
  end

  // Interrupt enable and sticky status.
  assign next_irq_en = wr_en ? bus.wdata[0] : irq_en;
  assign clr_req = wr_clr && bus.wdata[0];
  // A completion in the clearing cycle wins so the event is never lost.
  assign next_irq_stat = done_evt ? 1'b1 : clr_req ? 1'b0 : irq_stat;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_en <= 1'b0;
    end else begin
      irq_en <= next_irq_en;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      irq_stat <= 1'b0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  assign o_irq = irq_stat && irq_en;

  // Read multiplexer.
  // Data is zero outside a read so that the bus sees no stale value.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (bus.rd) begin
      case (bus.addr)
        RNGMON_CTRL_OFS: begin
          next_rdata = {16'h0000, ctrl};
        end
        RNGMON_CALC_OFS: begin
          next_rdata = calc_cnt;
        end
        RNGMON_DONE_OFS: begin
          next_rdata = {31'h0, done};
        end
        RNGMON_CYC_OFS: begin
          next_rdata = cyc_cnt;
        end
        RNGMON_IRQ_STAT_OFS: begin
          next_rdata = {31'h0, irq_stat};
        end
        RNGMON_IRQ_EN_OFS: begin
          next_rdata = {31'h0, irq_en};
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_rdata <= 32'h0000_0000;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // The cycle count register takes no writes; software sees it as read-only.
  // The clear register is write-only and reads zero through the default branch.
  // Rings are sampled as synchronous levels, so a ring faster than half the
  // system clock is undercounted; this monitor is meant for slow rings.

endmodule : rngmon_top

/* File: test/rngmon_assertions.sv */
`timescale 1ns/1ps
module rngmon_chk (
  // Watched ports.
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic [2:0] i_ring_clk,
  input wire logic [2:0] o_ring_en,
  input wire logic o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  wire cw = i_wr && i_addr == 8'h80;
  wire sw = cw && i_wdata[19:17] == 3'h7 && i_wdata[1];
  wire [2:0] hot = i_wdata[3:2] == 2'h3 ? 3'h0 : 3'h1 << i_wdata[3:2];
  a_rdata_idle: assert property (!$past(i_rd) |-> !o_rdata) else $error("stray data");
  a_ring_hot: assert property ($onehot0(o_ring_en)) else $error("two rings");
  a_ring_sel: assert property ($past(sw) |-> o_ring_en == $past(hot)) else $error("sel");
  a_mask_hold: assert property ($past(cw && i_wdata[19:17] == 3'h0) |-> $stable(o_ring_en))
    else $error("masked");
  a_en_off: assert property ($past(cw && i_wdata[17] && !i_wdata[1]) |-> !o_ring_en)
    else $error("ring on");
  a_done_bits: assert property ($past(i_rd && i_addr == 8'h88) |-> !o_rdata[31:1])
    else $error("done bits");
  a_irq_off: assert property ($past(i_wr && i_addr == 8'h94 && !i_wdata[0]) |-> !o_irq)
    else $error("irq");
  a_ring_reset: assert property ($rose(i_resetn) |-> !o_ring_en) else $error("reset");
  c_irq: cover property (o_irq);
  c_done: cover property ($past(i_rd && i_addr == 8'h88) && o_rdata[0]);
  c_ring2: cover property (o_ring_en == 3'h4);
endmodule : rngmon_chk
bind rngmon_top rngmon_chk u_rngmon_chk (.*);

/* File: test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic i_clk = 0, i_resetn = 0, i_wr = 0, i_rd = 0, o_irq;
  logic [7:0] i_addr = 8'h0;
  logic [31:0] i_wdata = 32'h0, o_rdata;
  logic [2:0] i_ring_clk = 3'h0, o_ring_en;
  int errors = 0, compares = 0, cycles = 0;
  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) i_ring_clk <= ~i_ring_clk;
  always @(posedge i_clk) if (++cycles > 900) begin
    errors++;
    test_done();
  end
  rngmon_top u_rngmon_top (.*);
  task chk(input logic [31:0] g, e);
    compares++;
    errors += int'(g !== e);
    if (g !== e) $display("Error %0t %h %h", $time, g, e);
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask : rd
  task test_done;
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // A ring toggling every cycle gives half the window as rising edges.
  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(8'h80, 32'h000e_0002 | s << 2);
      chk(o_ring_en, s == 3 ? 0 : 1 << s);
    end
    wr(8'h80, 32'h8000_8000);
    rd(8'h80, 32'he);
    wr(8'h80, 32'h0);
    rd(8'h80, 32'he);
    wr(8'h80, 32'h0002_0000);
    wr(8'h84, 32'h8);
    rd(8'h84, 32'h8);
    wr(8'h94, 32'h1);
    wr(8'h80, 32'h000f_000b);
    chk(o_ring_en, 32'h4);
    for (int i = 0; i < 20 && o_irq !== 1'b1; i++) @(posedge i_clk);
    rd(8'h88, 32'h1);
    rd(8'h8c, 32'h4);
    rd(8'h90, 32'h1);
    wr(8'h98, 32'h1);
    chk(o_irq, 32'h0);
    wr(8'h80, 32'h0001_0000);
    wr(8'h80, 32'h0001_0001);
    rd(8'h88, 32'h0);
    wr(8'h94, 32'h0);
    rd(8'ha0, 32'h0);
    test_done();
  end
endmodule : testbench
